//--- include/spa_pkg.sv
// shared constants, types and helpers of the serial port link
`default_nettype none
package spa_pkg;
  // ********************************
  // device register space
  // ********************************
  localparam int         REG_DEPTH  = 563;
  localparam logic [9:0] ADDR_CFG   = 10'h000;
  localparam logic [9:0] ADDR_ID    = 10'h003;
  localparam logic [9:0] ADDR_RBSEL = 10'h004;
  localparam logic [9:0] ADDR_TOP   = 10'h232;
  localparam logic [7:0] CFG_RESET  = 8'h18;
  localparam int         CFG_SDO    = 0;
  localparam int         CFG_LSB    = 1;
  localparam int         UPD_BIT    = 0;
  localparam int         RBSEL_BIT  = 0;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST  = 4'h7;
  localparam logic [5:0] INSTR_BITS = 6'h10;
  // ********************************
  // host command registers
  // ********************************
  localparam logic [7:0] HR_CTRL    = 8'h00;
  localparam logic [7:0] HR_ADDR    = 8'h04;
  localparam logic [7:0] HR_TXD     = 8'h08;
  localparam logic [7:0] HR_RXD     = 8'h0C;
  localparam logic [7:0] HR_STAT    = 8'h10;
  localparam logic [7:0] HR_CFG     = 8'h14;
  localparam logic [2:0] HALF_CYC   = 3'h6;
  // ********************************
  // types and helpers
  // ********************************
  typedef enum logic [1:0] {
    DS_INSTR = 2'h0,
    DS_DATA  = 2'h1,
    DS_DONE  = 2'h3
  } spa_dst_t;
  typedef enum logic {
    HS_IDLE = 1'h0,
    HS_RUN  = 1'h1
  } spa_hst_t;
  // position in a byte of the k-th bit on the wire
  function automatic logic [2:0] spa_bit_pos(input logic lsb, input logic [2:0] k);
    return lsb ? k : 3'h7 - k;
  endfunction
endpackage
`default_nettype wire

//--- include/spa_if.sv
// serial link between host and device, with wire resolution
`timescale 1ns/1ns
`default_nettype none
interface spa_if;
  logic sclk;
  logic cs_n;
  logic h_sdio_o;
  logic h_sdio_oe_n;
  logic d_sdio_o;
  logic d_sdio_oe_n;
  logic d_sdo_o;
  logic d_sdo_oe_n;
  logic sdio;
  logic sdo;
  // undriven lines read low
  assign sdio = !h_sdio_oe_n ? h_sdio_o : (!d_sdio_oe_n ? d_sdio_o : 1'h0);
  assign sdo  = !d_sdo_oe_n ? d_sdo_o : 1'h0;
  modport host (output sclk, cs_n, h_sdio_o, h_sdio_oe_n, input sdio, sdo);
  modport device (input sclk, cs_n, sdio, output d_sdio_o, d_sdio_oe_n, d_sdo_o, d_sdo_oe_n);
endinterface
`default_nettype wire

//--- hdl/spa_device.sv
// device end of the serial port: instruction decode, address generator, registers
// Operation
// - 16-bit instruction: direction, length, address
// - length codes: one, two, three bytes, stream
// - host sends top three address bits zero
// - msb first: address decrements per byte
// - host mirrors config nibbles on write
// - config resets to 0x18
// - bit order change acts immediately
// - msb first: host shifts msb first
// - lsb first: host shifts lsb first
// - lsb first: address increments per byte
// - streaming stops after address 0x232
// - every address visited, none skipped
// - msb stream wraps 0x000 to 0x232, stops
// - sample on rising, launch on falling
// - host ends stream by raising select
// - writes buffered until update bit set; config and readback select act at once
// - config bit 0 routes readback
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module spa_device #(
  parameter logic [7:0] PART_ID = 8'h5A      // arbitrary identification value
) (
  spa_if.device           lnk,               // serial link
  input  wire logic       i_clk,             // system clock
  input  wire logic       i_rst,             // synchronous reset, high
  input  wire logic       i_ce,              // system clock enable
  input  wire logic [9:0] i_act_addr,        // active register address
  output logic      [7:0] o_act_data,        // active register value
  output logic            o_update           // pulse: update executed
);
  import spa_pkg::*;
  // ********************************
  // state
  // ********************************
  logic       rst_q,  rst_d;
  logic [2:0] usy_q,  usy_d;
  logic       ufl_q,  ufl_d;
  logic       upd_q,  upd_d;
  logic [7:0] aout_q, aout_d;
  spa_dst_t   st_q,   st_d;
  logic [3:0] cnt_q,  cnt_d;
  logic [15:0] sh_q,  sh_d;
  logic       rd_q,   rd_d;
  logic [1:0] len_q,  len_d;
  logic [1:0] left_q, left_d;
  logic [9:0] adr_q,  adr_d;
  logic [7:0] rsh_q,  rsh_d;
  logic [7:0] cfg_q,  cfg_d;
  logic       rbs_q,  rbs_d;
  logic       seen_q, seen_d;
  logic       utg_q,  utg_d;
  logic       brk_q,  brk_d;
  logic       bit_q,  bit_d;
  logic       oe_q,   oe_d;
  logic       we;
  logic       copy;
  logic [7:0] wdat;
  logic       oe_n;
  logic [7:0] bufm    [REG_DEPTH];
  logic [7:0] act_mem [REG_DEPTH];

  // readback source for one address
  function automatic logic [7:0] rd_byte(input logic [9:0] a);
    if (a == ADDR_CFG) return cfg_q;
    if (a == ADDR_ID) return PART_ID;
    if (a > ADDR_TOP) return 8'h00;
    return rbs_q ? act_mem[a] : bufm[a];
  endfunction

  // ********************************
  // system clock side
  // ********************************
  always_comb begin
    rst_d  = i_rst;
    usy_d  = {usy_q[1:0], utg_q};
    ufl_d  = (usy_q[1] == usy_q[2]) ? usy_q[2] : ufl_q;
    upd_d  = ufl_d ^ ufl_q;
    // the active copy only moves at an update, so a read here can show new data a few cycles before o_update pulses
    aout_d = (i_act_addr <= ADDR_TOP) ? act_mem[i_act_addr] : 8'h00;
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_rst) begin
        rst_q  <= 1'h1;
        usy_q  <= 3'h0;
        ufl_q  <= 1'h0;
        upd_q  <= 1'h0;
        aout_q <= 8'h00;
      end else begin
        rst_q  <= rst_d;
        usy_q  <= usy_d;
        ufl_q  <= ufl_d;
        upd_q  <= upd_d;
        aout_q <= aout_d;
      end
    end
  end

  assign o_act_data = aout_q;
  assign o_update   = upd_q;

  // ********************************
  // select edge: abort marker
  // ********************************
  // sclk is idle while select is high, so the link state read here is steady
  always_comb begin
    brk_d = brk_q ^ ((cnt_q != 4'h0) || ((len_q == LEN_STREAM) && (st_q != DS_INSTR)));
  end

  always_ff @(posedge lnk.cs_n or posedge rst_q) begin
    if (rst_q) begin
      brk_q <= 1'h0;
    end else begin
      brk_q <= brk_d;
    end
  end

  // ********************************
  // link side: rising edge
  // ********************************
  always_comb begin
    logic        fresh;
    logic        lsb;
    logic [3:0]  c;
    logic [15:0] shn;
    logic [7:0]  byt;
    logic [9:0]  nxt;
    logic        last;
    fresh  = brk_q != seen_q;
    lsb    = cfg_q[CFG_LSB];
    c      = fresh ? 4'h0 : cnt_q;
    seen_d = brk_q;
    st_d   = fresh ? DS_INSTR : st_q;
    cnt_d  = c;
    sh_d   = sh_q;
    rd_d   = rd_q;
    len_d  = len_q;
    left_d = left_q;
    adr_d  = adr_q;
    rsh_d  = rsh_q;
    cfg_d  = cfg_q;
    rbs_d  = rbs_q;
    utg_d  = utg_q;
    we     = 1'h0;
    copy   = 1'h0;
    wdat   = 8'h00;
    shn    = lsb ? {lnk.sdio, sh_q[15:1]} : {sh_q[14:0], lnk.sdio};
    byt    = lsb ? shn[15:8] : shn[7:0];
    nxt    = lsb ? adr_q + 10'h001 : adr_q - 10'h001;
    if (!lsb && (adr_q == ADDR_CFG)) begin
      nxt = ADDR_TOP;
    end
    last   = (len_q == LEN_STREAM) ? (adr_q == ADDR_TOP) : (left_q == 2'h0);
    unique case (st_d)
      DS_INSTR: begin
        sh_d = shn;
        if (c == INSTR_LAST) begin
          rd_d   = shn[15];
          len_d  = shn[14:13];
          left_d = shn[14:13];
          adr_d  = shn[9:0];
          rsh_d  = rd_byte(shn[9:0]);
          st_d   = DS_DATA;
          cnt_d  = 4'h0;
        end else begin
          cnt_d = c + 4'h1;
        end
      end
      DS_DATA: begin
        sh_d = shn;
        if (c == BYTE_LAST) begin
          if (!rd_q) begin
            if (adr_q == ADDR_CFG) begin
              cfg_d = byt;
            end else begin
              we   = adr_q <= ADDR_TOP;
              wdat = byt;
            end
            if (adr_q == ADDR_RBSEL) begin
              rbs_d = byt[RBSEL_BIT];
            end
            if (adr_q == ADDR_TOP) begin
              wdat[UPD_BIT] = 1'h0;
              copy  = byt[UPD_BIT];
              utg_d = utg_q ^ byt[UPD_BIT];
            end
          end
          adr_d  = nxt;
          left_d = left_q - 2'h1;
          rsh_d  = rd_byte(nxt);
          cnt_d  = 4'h0;
          if (last) begin
            st_d = (len_q == LEN_STREAM) ? DS_DONE : DS_INSTR;
          end
        end else begin
          cnt_d = c + 4'h1;
        end
      end
      DS_DONE: begin
        cnt_d = c;
      end
    endcase
  end

  always_ff @(posedge lnk.sclk or posedge rst_q) begin
    if (rst_q) begin
      seen_q <= 1'h0;
      st_q   <= DS_INSTR;
      cnt_q  <= 4'h0;
      sh_q   <= 16'h0000;
      rd_q   <= 1'h0;
      len_q  <= 2'h0;
      left_q <= 2'h0;
      adr_q  <= 10'h000;
      rsh_q  <= 8'h00;
      cfg_q  <= CFG_RESET;
      rbs_q  <= 1'h0;
      utg_q  <= 1'h0;
    end else begin
      seen_q <= seen_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      len_q  <= len_d;
      left_q <= left_d;
      adr_q  <= adr_d;
      rsh_q  <= rsh_d;
      cfg_q  <= cfg_d;
      rbs_q  <= rbs_d;
      utg_q  <= utg_d;
    end
  end

  // buffer and active copy; the update moves every location at once
  always_ff @(posedge lnk.sclk) begin
    if (copy) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        act_mem[i] <= bufm[i];
      end
    end
    if (we) begin
      bufm[adr_q] <= wdat;
    end
  end

  // ********************************
  // link side: falling edge readback
  // ********************************
  always_comb begin
    bit_d = rsh_q[spa_bit_pos(cfg_q[CFG_LSB], cnt_q[2:0])];
    oe_d  = (st_q == DS_DATA) && rd_q;
  end

  always_ff @(negedge lnk.sclk or posedge rst_q) begin
    if (rst_q) begin
      bit_q <= 1'h0;
      oe_q  <= 1'h0;
    end else begin
      bit_q <= bit_d;
      oe_q  <= oe_d;
    end
  end

  assign oe_n            = lnk.cs_n | !oe_q;
  assign lnk.d_sdio_o    = bit_q;
  assign lnk.d_sdo_o     = bit_q;
  assign lnk.d_sdio_oe_n = oe_n | cfg_q[CFG_SDO];
  assign lnk.d_sdo_oe_n  = oe_n | !cfg_q[CFG_SDO];
endmodule
`default_nettype wire

//--- hdl/spa_host.sv
// host end of the serial port: command registers, clock divider, shifter
`timescale 1ns/1ns
`default_nettype none
module spa_host (
  spa_if.host              lnk,              // serial link
  input  wire logic        i_clk,            // system clock
  input  wire logic        i_rst,            // synchronous reset, high
  input  wire logic        i_ce,             // clock enable
  input  wire logic [7:0]  i_addr,           // register byte address
  input  wire logic [31:0] i_wdata,          // write data
  input  wire logic        i_wr,             // write strobe
  input  wire logic        i_rd,             // read strobe
  output logic      [31:0] o_rdata           // read data, cycle after strobe
);
  import spa_pkg::*;
  // ********************************
  // state
  // ********************************
  spa_hst_t    st_q,   st_d;
  logic [2:0]  div_q,  div_d;
  logic        sclk_q, sclk_d;
  logic        csn_q,  csn_d;
  logic        dout_q, dout_d;
  logic        oen_q,  oen_d;
  logic [5:0]  bit_q,  bit_d;
  logic        rw_q,   rw_d;
  logic [1:0]  len_q,  len_d;
  logic [1:0]  scnt_q, scnt_d;
  logic [9:0]  adr_q,  adr_d;
  logic [31:0] txd_q,  txd_d;
  logic [31:0] rxd_q,  rxd_d;
  logic [1:0]  cfg_q,  cfg_d;
  logic        done_q, done_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0]  sy_q,   sy_d;
  logic        flt_q,  flt_d;

  // wire bit number b of the frame
  function automatic logic tx_bit(input logic [5:0] b, input logic [15:0] ins,
                                  input logic [31:0] dat, input logic lsb);
    logic [5:0] d;
    d = b - INSTR_BITS;
    if (b < INSTR_BITS) return ins[lsb ? b[3:0] : 4'hF - b[3:0]];
    return dat[{d[4:3], spa_bit_pos(lsb, d[2:0])}];
  endfunction

  always_comb begin
    logic        idle;
    logic        rwx;
    logic        lsb;
    logic [2:0]  nby;
    logic [5:0]  lastb;
    logic [5:0]  d;
    logic [15:0] ins;
    logic [31:0] dat;
    idle   = st_q == HS_IDLE;
    lsb    = cfg_q[CFG_LSB];
    st_d   = st_q;
    div_d  = div_q;
    sclk_d = sclk_q;
    csn_d  = csn_q;
    dout_d = dout_q;
    oen_d  = oen_q;
    bit_d  = bit_q;
    rw_d   = rw_q;
    len_d  = len_q;
    scnt_d = scnt_q;
    adr_d  = adr_q;
    txd_d  = txd_q;
    rxd_d  = rxd_q;
    cfg_d  = cfg_q;
    done_d = done_q;
    rdat_d = 32'h0000_0000;
    // ********************************
    // command registers
    // ********************************
    if (i_wr && idle) begin
      if (i_addr == HR_ADDR) adr_d = i_wdata[9:0];
      if (i_addr == HR_TXD) txd_d = i_wdata;
      if (i_addr == HR_CFG) cfg_d = i_wdata[1:0];
    end
    if (i_wr && (i_addr == HR_STAT) && i_wdata[1]) done_d = 1'h0;
    if (i_rd) begin
      unique case (i_addr)
        HR_CTRL: rdat_d = {26'h0, scnt_q, len_q, rw_q, 1'h0};
        HR_ADDR: rdat_d = {22'h0, adr_q};
        HR_TXD:  rdat_d = txd_q;
        HR_RXD:  rdat_d = rxd_q;
        HR_STAT: rdat_d = {30'h0, done_q, !idle};
        HR_CFG:  rdat_d = {30'h0, cfg_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    // ********************************
    // link sequencer
    // ********************************
    sy_d  = {sy_q[1:0], cfg_q[CFG_SDO] ? lnk.sdo : lnk.sdio};
    flt_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : flt_q;
    rwx   = idle ? i_wdata[1] : rw_q;
    ins   = {rwx, idle ? i_wdata[3:2] : len_q, 3'h0, adr_q};
    dat   = txd_q;
    if (!rwx && (adr_q == ADDR_CFG)) begin
      dat[7:4] = {txd_q[0], txd_q[1], txd_q[2], txd_q[3]};
    end
    nby   = (len_q == LEN_STREAM) ? {1'h0, scnt_q} + 3'h1 : {1'h0, len_q} + 3'h1;
    lastb = INSTR_BITS - 6'h01 + {nby, 3'h0};
    d     = bit_q - INSTR_BITS;
    unique case (st_q)
      HS_IDLE: begin
        if (i_wr && (i_addr == HR_CTRL) && i_wdata[0]) begin
          rw_d   = i_wdata[1];
          len_d  = i_wdata[3:2];
          scnt_d = i_wdata[5:4];
          rxd_d  = 32'h0000_0000;
          st_d   = HS_RUN;
          csn_d  = 1'h0;
          div_d  = 3'h0;
          bit_d  = 6'h00;
          dout_d = tx_bit(6'h00, ins, dat, lsb);
          oen_d  = 1'h0;
        end
      end
      HS_RUN: begin
        if (div_q == HALF_CYC - 3'h1) begin
          div_d = 3'h0;
          if (!sclk_q) begin
            sclk_d = 1'h1;
            if (rw_q && (bit_q >= INSTR_BITS)) begin
              rxd_d[{d[4:3], spa_bit_pos(lsb, d[2:0])}] = flt_q;
            end
          end else begin
            sclk_d = 1'h0;
            if (bit_q == lastb) begin
              csn_d  = 1'h1;
              oen_d  = 1'h1;
              done_d = 1'h1;
              st_d   = HS_IDLE;
            end else begin
              bit_d  = bit_q + 6'h01;
              dout_d = tx_bit(bit_d, ins, dat, lsb);
              oen_d  = rw_q && (bit_d >= INSTR_BITS);
            end
          end
        end else begin
          div_d = div_q + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_rst) begin
        st_q   <= HS_IDLE;
        div_q  <= 3'h0;
        sclk_q <= 1'h0;
        csn_q  <= 1'h1;
        dout_q <= 1'h0;
        oen_q  <= 1'h1;
        bit_q  <= 6'h00;
        rw_q   <= 1'h0;
        len_q  <= 2'h0;
        scnt_q <= 2'h0;
        adr_q  <= 10'h000;
        txd_q  <= 32'h0000_0000;
        rxd_q  <= 32'h0000_0000;
        cfg_q  <= 2'h0;
        done_q <= 1'h0;
        rdat_q <= 32'h0000_0000;
        sy_q   <= 3'h0;
        flt_q  <= 1'h0;
      end else begin
        st_q   <= st_d;
        div_q  <= div_d;
        sclk_q <= sclk_d;
        csn_q  <= csn_d;
        dout_q <= dout_d;
        oen_q  <= oen_d;
        bit_q  <= bit_d;
        rw_q   <= rw_d;
        len_q  <= len_d;
        scnt_q <= scnt_d;
        adr_q  <= adr_d;
        txd_q  <= txd_d;
        rxd_q  <= rxd_d;
        cfg_q  <= cfg_d;
        done_q <= done_d;
        rdat_q <= rdat_d;
        sy_q   <= sy_d;
        flt_q  <= flt_d;
      end
    end
  end

  assign o_rdata         = rdat_q;
  assign lnk.sclk        = sclk_q;
  assign lnk.cs_n        = csn_q;
  assign lnk.h_sdio_o    = dout_q;
  assign lnk.h_sdio_oe_n = oen_q;
endmodule
`default_nettype wire

//--- tb/spa_link_properties.sv
// concurrent checks on the serial link between host and device
`timescale 1ns/1ns
`default_nettype none
module spa_link_properties (
  input wire logic i_clk,        // system clock
  input wire logic i_rst,        // sync reset, high
  input wire logic sclk,         // serial clock
  input wire logic cs_n,         // select, low active
  input wire logic h_sdio_oe_n,  // host drives sdio when low
  input wire logic d_sdio_oe_n,  // device drives sdio when low
  input wire logic d_sdo_oe_n,   // device drives sdo when low
  input wire logic sdio,         // resolved data line
  input wire logic sdo           // resolved readback line
);
  // ********************************
  // rising edges counted within a frame
  // ********************************
  logic       sclk_q;
  logic       sclk_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  always_comb begin
    sclk_d = sclk;
    cnt_d  = cnt_q;
    if (cs_n) begin
      cnt_d = 10'h000;
    end else if (sclk && !sclk_q) begin
      cnt_d = cnt_q + 10'h001;
    end
  end
  always_ff @(posedge i_clk) begin
    sclk_q <= i_rst ? 1'b0 : sclk_d;
    cnt_q  <= i_rst ? 10'h000 : cnt_d;
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("serial clock high phase is not six cycles");
  AST_DATA_STABLE: assert property ($rose(sclk) |-> $stable(sdio) && $stable(sdo))
    else $error("data line moved at a rising serial clock edge");
  AST_QUIET_CLOCK: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_FRAME_BYTES: assert property ($rose(cs_n) |-> cnt_q[2:0] == 3'h0 && cnt_q >= 10'h018)
    else $error("frame did not end on a byte boundary after the instruction");
  AST_NO_CONTENTION: assert property (!(!h_sdio_oe_n && !d_sdio_oe_n))
    else $error("host and device drive sdio together");
  AST_ONE_PIN: assert property (!(!d_sdio_oe_n && !d_sdo_oe_n))
    else $error("readback driven on both pins");
  AST_DEV_QUIET: assert property (cs_n && $past(cs_n) |-> d_sdio_oe_n && d_sdo_oe_n)
    else $error("device drives while deselected");
  AST_READ_AFTER_INSTR: assert property (!d_sdio_oe_n || !d_sdo_oe_n |-> cnt_q >= 10'h010)
    else $error("device drove before the instruction was complete");
  AST_RESET_IDLE: assert property ($fell(i_rst) |-> cs_n && !sclk && h_sdio_oe_n)
    else $error("link not idle after reset");
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ns
`default_nettype none
module tb;
  import spa_pkg::*;
  localparam logic [7:0] ID = 8'hA5;  // arbitrary identification value
  logic        i_clk;
  logic        i_rst;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  i_addr;
  logic [7:0]  o_act_data;
  logic [9:0]  i_act_addr;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  logic [31:0] rdat;
  logic        o_update;
  logic [7:0]  upd_cnt = 8'h00;
  int          num_errors = 0;
  int          comparisons = 0;
  spa_if lnk ();
  spa_host i_spa_host (.lnk(lnk), .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  spa_device #(.PART_ID(ID)) i_spa_device (.lnk(lnk), .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_act_addr(i_act_addr), .o_act_data(o_act_data), .o_update(o_update));
  spa_link_properties i_props (.i_clk(i_clk), .i_rst(i_rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .h_sdio_oe_n(lnk.h_sdio_oe_n), .d_sdio_oe_n(lnk.d_sdio_oe_n), .d_sdo_oe_n(lnk.d_sdo_oe_n),
    .sdio(lnk.sdio), .sdo(lnk.sdo));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // update pulses land before the host reports done, so count them here
  always @(posedge i_clk) begin
    if (o_update === 1'b1) begin
      upd_cnt <= upd_cnt + 8'h01;
    end
  end
  // ********************************
  // checks and bus cycles
  // ********************************
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rx(input logic [31:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      chk8("read byte", e[8*i+:8], rdat[8*i+:8]);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rdat = o_rdata;
  endtask
  // one framed transfer; read bytes end up in rdat
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [9:0] a, input logic [31:0] tx,
                      input logic [1:0] sc);
    int n;
    bus_wr(HR_ADDR, {22'h000000, a});
    bus_wr(HR_TXD, tx);
    bus_wr(HR_CTRL, {26'h0000000, sc, len, rd, 1'b1});
    n    = 0;
    rdat = 32'h00000000;
    while (rdat[1] !== 1'b1 && n < 1000) begin
      bus_rd(HR_STAT);
      n++;
    end
    if (n >= 1000) begin
      num_errors++;
      $display("BAD done expected 1 seen %b", rdat[1]);
      complete_run();
    end
    bus_wr(HR_STAT, 32'h00000002);
    if (rd) begin
      bus_rd(HR_RXD);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_ident;
    xfer(1'b1, 2'h0, ADDR_CFG, 32'h0, 2'h0);
    chk8("config", CFG_RESET, rdat[7:0]);
    xfer(1'b1, 2'h0, ADDR_ID, 32'h0, 2'h0);
    chk8("part id", ID, rdat[7:0]);
    bus_rd(8'h18);
    chk8("unmapped", 8'h00, rdat[7:0]);
  endtask
  task automatic t_msb_multi;
    logic [7:0] u0;
    xfer(1'b0, 2'h2, 10'h012, 32'h00C3B2A1, 2'h0);
    xfer(1'b1, 2'h2, 10'h012, 32'h0, 2'h0);
    chk_rx(32'h00C3B2A1, 3);
    xfer(1'b1, 2'h1, 10'h011, 32'h0, 2'h0);
    chk_rx(32'h0000C3B2, 2);
    u0 = upd_cnt;
    xfer(1'b0, 2'h0, ADDR_TOP, 32'h00000001, 2'h0);
    chk8("updates", u0 + 8'h01, upd_cnt);
    @(posedge i_clk);
    i_act_addr <= 10'h011;
    repeat (2) @(posedge i_clk);
    #1 chk8("active", 8'hB2, o_act_data);
    // buffer now differs from the active copy until the next update
    xfer(1'b0, 2'h0, 10'h011, 32'h00000044, 2'h0);
    xfer(1'b0, 2'h0, ADDR_RBSEL, 32'h00000001, 2'h0);
    xfer(1'b1, 2'h0, 10'h011, 32'h0, 2'h0);
    chk8("active readback", 8'hB2, rdat[7:0]);
    xfer(1'b0, 2'h0, ADDR_RBSEL, 32'h00000000, 2'h0);
    xfer(1'b1, 2'h0, 10'h011, 32'h0, 2'h0);
    chk8("buffer readback", 8'h44, rdat[7:0]);
  endtask
  task automatic t_stream_wrap;
    logic [7:0] u0;
    u0 = upd_cnt;
    xfer(1'b0, LEN_STREAM, 10'h001, 32'h00011855, 2'h2);
    chk8("updates", u0 + 8'h01, upd_cnt);
    xfer(1'b1, LEN_STREAM, 10'h001, 32'h0, 2'h3);
    chk_rx(32'h00001855, 4);
  endtask
  task automatic t_lsb;
    xfer(1'b0, 2'h0, ADDR_CFG, 32'h0000005A, 2'h0);
    bus_wr(HR_CFG, 32'h00000002);
    xfer(1'b0, 2'h1, 10'h230, 32'h00007766, 2'h0);
    xfer(1'b1, LEN_STREAM, 10'h230, 32'h0, 2'h3);
    chk_rx(32'h00007766, 4);
    xfer(1'b1, 2'h0, ADDR_CFG, 32'h0, 2'h0);
    chk8("config", 8'h5A, rdat[7:0]);
    xfer(1'b0, 2'h0, ADDR_CFG, 32'h00000018, 2'h0);
    bus_wr(HR_CFG, 32'h00000000);
  endtask
  task automatic t_sdo_pin;
    xfer(1'b0, 2'h0, ADDR_CFG, 32'h00000099, 2'h0);
    bus_wr(HR_CFG, 32'h00000001);
    xfer(1'b1, 2'h0, 10'h012, 32'h0, 2'h0);
    chk8("sdo read", 8'hA1, rdat[7:0]);
    xfer(1'b0, 2'h0, ADDR_CFG, 32'h00000018, 2'h0);
    bus_wr(HR_CFG, 32'h00000000);
    xfer(1'b1, 2'h0, ADDR_CFG, 32'h0, 2'h0);
    chk8("config", CFG_RESET, rdat[7:0]);
  endtask
  initial begin
    #(100 * 60000);
    num_errors++;
    $display("BAD watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    i_rst      = 1'b1;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    i_addr     = 8'h00;
    i_wdata    = 32'h00000000;
    i_act_addr = 10'h000;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    t_ident();
    t_msb_multi();
    t_stream_wrap();
    t_lsb();
    t_sdo_pin();
    complete_run();
  end
endmodule
`default_nettype wire
